// *** verilog/sdx_defines.svh ***
// offsets, bit positions, reset values of the smbus control registers
`ifndef SDX_DEFINES_SVH
`define SDX_DEFINES_SVH
`define SDX_OFS_DDR      8'h01
`define SDX_OFS_ARB      8'h02
`define SDX_DDR_RESET    8'h00
`define SDX_ARB_RESET    8'h00
`define SDX_DDR_WMASK    8'heb
`define SDX_ARB_WMASK    8'h05
`define SDX_BIT_FWP      0
`define SDX_BIT_LOCK     1
`define SDX_BIT_RSVD     2
`define SDX_BIT_FLOPPY   3
`define SDX_BIT_UART2    5
`define SDX_BIT_UART1    6
`define SDX_BIT_PARALLEL 7
`define SDX_BIT_REQ      0
`define SDX_BIT_GNT      1
`define SDX_BIT_MREQ     2
`endif

// *** verilog/sdx_pkg.sv ***
// types shared by the smbus control register bank
package sdx_pkg;
	typedef enum logic [1:0] {
		SDX_ARB_IDLE = 2'b00,
		SDX_ARB_HOST = 2'b01,
		SDX_ARB_SMB  = 2'b11
	} sdx_arb_t;
	typedef logic [7:0] sdx_byte_t;
endpackage

// *** verilog/sdx_regs.sv ***
// device disable and external bus arbitration registers, smbus side

`include "sdx_defines.svh"

module sdx_regs
	import sdx_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       pci_reset,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	input  wire logic       floppy_protect_line_n,
	input  wire logic       drive_select_zero_n,
	input  wire logic       drive_select_one_n,
	input  wire logic       force_write_protect,
	input  wire logic       floppy_controller_activate,
	input  wire logic       uart1_activate,
	input  wire logic       uart2_activate,
	input  wire logic       parallel_port_activate,
	input  wire logic       host_side_bus_request,
	output logic [7:0]      reg_rdata_q,
	output logic            reg_rvalid_q,
	output logic            floppy_write_protect_q,
	output logic            floppy_enable_q,
	output logic            uart1_enable_q,
	output logic            uart2_enable_q,
	output logic            parallel_enable_q,
	output logic            smbus_side_bus_grant_q,
	output logic            host_side_bus_grant_q,
	output logic            host_cycle_abort_q
);

	// address decode shared by write and read paths
	function automatic logic reg_hit(input logic [7:0] a,
		input logic [7:0] ofs);
		reg_hit = (a == ofs);
	endfunction

	logic rst;
	assign rst = reset | pci_reset;

	// pin synchroniser: three stages, change taken when last two agree
	logic [2:0] wp_sync_q;
	logic [2:0] wp_sync_d;
	logic       wp_pin_q;
	logic       wp_pin_d;

	always_comb begin
		wp_sync_d = {wp_sync_q[1:0], floppy_protect_line_n};
		wp_pin_d  = wp_pin_q;
		if (wp_sync_q[2] == wp_sync_q[1]) begin
			wp_pin_d = wp_sync_q[2];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_sync_q <= 3'h0;
			wp_pin_q  <= 1'b0;
		end else begin
			wp_sync_q <= wp_sync_d;
			wp_pin_q  <= wp_pin_d;
		end
	end

	// register file state
	sdx_byte_t ddr_q;
	sdx_byte_t ddr_d;
	sdx_byte_t arb_q;
	sdx_byte_t arb_d;
	logic [7:0] rdata_d;
	logic       rvalid_d;
	logic       lock;
	logic       wr_ddr;
	logic       wr_arb;
	logic       override;

	assign lock     = ddr_q[`SDX_BIT_LOCK];
	assign override = arb_q[`SDX_BIT_MREQ];
	assign wr_ddr   = reg_wr & reg_hit(reg_addr, `SDX_OFS_DDR);
	assign wr_arb   = reg_wr & reg_hit(reg_addr, `SDX_OFS_ARB);

	// writes and read mux; grant bit comes from the arbiter, not storage
	always_comb begin
		ddr_d    = ddr_q;
		arb_d    = arb_q;
		rdata_d  = reg_rdata_q;
		rvalid_d = reg_rd;
		if (wr_ddr && !lock) begin
			ddr_d = reg_wdata & `SDX_DDR_WMASK;
		end
		if (wr_arb) begin
			arb_d = reg_wdata & `SDX_ARB_WMASK;
		end
		if (reg_rd) begin
			rdata_d = 8'h00;
			if (reg_hit(reg_addr, `SDX_OFS_DDR)) begin
				rdata_d = ddr_q;
			end else if (reg_hit(reg_addr, `SDX_OFS_ARB)) begin
				rdata_d = arb_q;
				rdata_d[`SDX_BIT_GNT] = smbus_side_bus_grant_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ddr_q        <= `SDX_DDR_RESET;
			arb_q        <= `SDX_ARB_RESET;
			reg_rdata_q  <= 8'h00;
			reg_rvalid_q <= 1'b0;
		end else begin
			ddr_q        <= ddr_d;
			arb_q        <= arb_d;
			reg_rdata_q  <= rdata_d;
			reg_rvalid_q <= rvalid_d;
		end
	end

	// peripheral gating; the enables feed both host and smbus decoders
	logic wp_d;
	logic floppy_en_d;
	logic u1_en_d;
	logic u2_en_d;
	logic parallel_en_d;

	always_comb begin
		wp_d = ddr_q[`SDX_BIT_FWP] | wp_pin_q
			| (drive_select_zero_n & force_write_protect)
			| (drive_select_one_n & force_write_protect);
		floppy_en_d = floppy_controller_activate
			& ~ddr_q[`SDX_BIT_FLOPPY];
		u2_en_d = uart2_activate & ~ddr_q[`SDX_BIT_UART2];
		u1_en_d = uart1_activate & ~ddr_q[`SDX_BIT_UART1];
		parallel_en_d = parallel_port_activate
			& ~ddr_q[`SDX_BIT_PARALLEL];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			floppy_write_protect_q <= 1'b0;
			floppy_enable_q        <= 1'b0;
			uart1_enable_q         <= 1'b0;
			uart2_enable_q         <= 1'b0;
			parallel_enable_q      <= 1'b0;
		end else begin
			floppy_write_protect_q <= wp_d;
			floppy_enable_q        <= floppy_en_d;
			uart1_enable_q         <= u1_en_d;
			uart2_enable_q         <= u2_en_d;
			parallel_enable_q      <= parallel_en_d;
		end
	end

	// arbiter; ties from idle go to the host side unless override is set, and a tie never flips the owner back
	sdx_arb_t st_q;
	sdx_arb_t st_d;
	logic     abort_d;
	logic     smbus_side_bus_request;
	logic     smbus_side_bus_grant_d;
	logic     host_gnt_d;

	assign smbus_side_bus_request = arb_q[`SDX_BIT_REQ];

	always_comb begin
		st_d    = st_q;
		abort_d = 1'b0;
		case (st_q)
			SDX_ARB_IDLE: begin
				if (override) begin
					st_d = SDX_ARB_SMB;
				end else if (host_side_bus_request) begin
					st_d = SDX_ARB_HOST;
				end else if (smbus_side_bus_request) begin
					st_d = SDX_ARB_SMB;
				end
			end
			SDX_ARB_HOST: begin
				if (override) begin
					st_d    = SDX_ARB_SMB;
					abort_d = 1'b1;
				end else if (!host_side_bus_request) begin
					if (smbus_side_bus_request) begin
						st_d    = SDX_ARB_SMB;
						abort_d = 1'b1;
					end else begin
						st_d = SDX_ARB_IDLE;
					end
				end
			end
			SDX_ARB_SMB: begin
				if (!smbus_side_bus_request && !override) begin
					if (host_side_bus_request) begin
						st_d = SDX_ARB_HOST;
					end else begin
						st_d = SDX_ARB_IDLE;
					end
				end
			end
			default: begin
				st_d = SDX_ARB_HOST;
			end
		endcase
		// grants decoded here so the flops only register
		smbus_side_bus_grant_d  = (st_d == SDX_ARB_SMB);
		host_gnt_d = (st_d == SDX_ARB_HOST);
	end

	// host owns the bus after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q                   <= SDX_ARB_HOST;
			smbus_side_bus_grant_q <= 1'b0;
			host_side_bus_grant_q  <= 1'b1;
			host_cycle_abort_q     <= 1'b0;
		end else begin
			st_q                   <= st_d;
			smbus_side_bus_grant_q <= smbus_side_bus_grant_d;
			host_side_bus_grant_q  <= host_gnt_d;
			host_cycle_abort_q     <= abort_d;
		end
	end

	// checks
	sequence seq_handover;
		host_cycle_abort_q && smbus_side_bus_grant_q
			&& !host_side_bus_grant_q;
	endsequence

	sequence seq_host_held;
		host_side_bus_grant_q && host_side_bus_request && !override;
	endsequence

	chk_reset_zero: assert property (
		@(posedge clk) rst |=> (ddr_q == 8'h00) && (arb_q == 8'h00))
		else $error("registers not cleared by reset");

	chk_lock_holds: assert property (
		@(posedge clk) disable iff (rst)
		(lock && wr_ddr) |=> $stable(ddr_q))
		else $error("locked register changed");

	chk_write_lands: assert property (
		@(posedge clk) disable iff (rst)
		(!lock && wr_ddr) |=> ddr_q == ($past(reg_wdata) & 8'heb))
		else $error("unlocked write lost");

	chk_protect_or: assert property (
		@(posedge clk) disable iff (rst)
		ddr_q[0] |=> floppy_write_protect_q)
		else $error("forced protect not seen");

	chk_rsvd_zero: assert property (
		@(posedge clk) disable iff (rst)
		reg_rd && reg_hit(reg_addr, 8'h01) |=> !reg_rdata_q[2])
		else $error("reserved bit read one");

	chk_floppy_off: assert property (
		@(posedge clk) disable iff (rst)
		ddr_q[3] |=> !floppy_enable_q)
		else $error("floppy not disabled");

	chk_uart_off: assert property (
		@(posedge clk) disable iff (rst)
		ddr_q[5] || ddr_q[6] |=>
			!(uart2_enable_q && $past(ddr_q[5]))
			&& !(uart1_enable_q && $past(ddr_q[6])))
		else $error("serial port not disabled");

	chk_parallel_off: assert property (
		@(posedge clk) disable iff (rst)
		ddr_q[7] |=> !parallel_enable_q)
		else $error("parallel port not disabled");

	chk_grant_excl: assert property (
		@(posedge clk) disable iff (rst)
		!(smbus_side_bus_grant_q && host_side_bus_grant_q))
		else $error("both sides granted");

	chk_host_held: assert property (
		@(posedge clk) disable iff (rst)
		seq_host_held |=> host_side_bus_grant_q)
		else $error("host grant lost while held");

	chk_override_cut: assert property (
		@(posedge clk) disable iff (rst)
		(host_side_bus_grant_q && override) |=> seq_handover)
		else $error("override did not cut host off");

	chk_early_drop: assert property (
		@(posedge clk) disable iff (rst)
		(host_side_bus_grant_q && !host_side_bus_request && smbus_side_bus_request)
			|=> seq_handover)
		else $error("early release not handed over");

endmodule

// *** tb/sdx_host_model.sv ***
// host-side requester model facing the external bus arbiter
module sdx_host_model (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic want,
	input  wire logic grant,
	output logic      host_side_bus_request,
	output logic      host_owns
);
	timeunit 1ns;
	timeprecision 1ps;
	// host requests from boot and holds for the whole transfer
	always_ff @(posedge clk) begin
		host_side_bus_request <= reset ? 1'b1 : want;
	end
	// cycles may start only once the grant is seen
	assign host_owns = host_side_bus_request & grant;
endmodule

// *** tb/test_sdx_regs.sv ***
// self-checking bench for the smbus control register bank
`include "sdx_defines.svh"
module test_sdx_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, reset, pci_reset, reg_wr, reg_rd, want, host_owns;
	logic       floppy_protect_line_n, drive_select_zero_n;
	logic       drive_select_one_n, force_write_protect;
	logic       host_side_bus_request, reg_rvalid_q, floppy_write_protect_q;
	logic       floppy_enable_q, uart1_enable_q, uart2_enable_q;
	logic       parallel_enable_q, smbus_side_bus_grant_q;
	logic       host_side_bus_grant_q, host_cycle_abort_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
	logic [3:0] act;
	int         err_total, checks_done, cycles, i;
	// rows: write value, read back, enables floppy/u1/u2/parallel, protect
	logic [20:0] rows [7] = '{{8'h08, 8'h08, 4'h7, 1'h0},
		{8'h40, 8'h40, 4'hb, 1'h0}, {8'h20, 8'h20, 4'hd, 1'h0},
		{8'h80, 8'h80, 4'he, 1'h0}, {8'h14, 8'h00, 4'hf, 1'h0},
		{8'he9, 8'he9, 4'h0, 1'h1}, {8'h00, 8'h00, 4'hf, 1'h0}};
	// pin, force, ds0, ds1, expected protect
	logic [4:0]  wpt [4] = '{5'b10001, 5'b01101, 5'b01011, 5'b01000};

	sdx_regs DUT (.clk, .reset, .pci_reset, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .floppy_protect_line_n, .drive_select_zero_n,
		.drive_select_one_n, .force_write_protect,
		.floppy_controller_activate(act[3]),
		.uart1_activate(act[2]), .uart2_activate(act[1]),
		.parallel_port_activate(act[0]), .host_side_bus_request,
		.reg_rdata_q,
		.reg_rvalid_q, .floppy_write_protect_q, .floppy_enable_q,
		.uart1_enable_q, .uart2_enable_q, .parallel_enable_q,
		.smbus_side_bus_grant_q, .host_side_bus_grant_q,
		.host_cycle_abort_q);
	sdx_host_model host (.clk, .reset(reset | pci_reset), .want,
		.grant(host_side_bus_grant_q), .host_side_bus_request, .host_owns);

	task automatic chk(input string what, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one-cycle strobes, released one edge after they are taken
	task automatic wr(input logic [7:0] a, d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		cyc(1);
		reg_addr = a;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		chk("rvalid", 8'(reg_rvalid_q), 8'h01);
		chk("rdata", reg_rdata_q, exp);
	endtask
	task automatic grants(input logic s, h);
		chk("smbus_side_bus_grant", 8'(smbus_side_bus_grant_q), 8'(s));
		chk("host_gnt", 8'(host_side_bus_grant_q), 8'(h));
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// free-running clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// hang guard, far above the 120 or so cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			wrap_up;
		end
	end
	initial begin
		{pci_reset, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{floppy_protect_line_n, force_write_protect} = 2'b00;
		{drive_select_zero_n, drive_select_one_n} = 2'b00;
		act = 4'hf;
		want = 1'b1;
		reset = 1'b1;
		cyc(6);
		reset = 1'b0;
		rd(`SDX_OFS_DDR, 8'h00);
		rd(`SDX_OFS_ARB, 8'h00);
		grants(1'b0, 1'b1);
		chk("host_owns", 8'(host_owns), 8'h01);
		for (i = 0; i < 7; i++) begin
			wr(`SDX_OFS_DDR, rows[i][20:13]);
			cyc(1);
			chk("enables", 8'({floppy_enable_q, uart1_enable_q,
				uart2_enable_q, parallel_enable_q}), 8'(rows[i][4:1]));
			chk("protect", 8'(floppy_write_protect_q), 8'(rows[i][0]));
			rd(`SDX_OFS_DDR, rows[i][12:5]);
		end
		$display("table done");
		// each protect term on its own
		for (i = 0; i < 4; i++) begin
			{floppy_protect_line_n, force_write_protect} = wpt[i][4:3];
			{drive_select_zero_n, drive_select_one_n} = wpt[i][2:1];
			cyc(6);
			chk("protect", 8'(floppy_write_protect_q), 8'(wpt[i][0]));
		end
		// enables follow activates when nothing is disabled
		act = 4'h5;
		cyc(2);
		chk("enables", 8'({floppy_enable_q, uart1_enable_q,
			uart2_enable_q, parallel_enable_q}), 8'h05);
		rd(8'h03, 8'h00);
		$display("protect and activate done");
		// second requester waits while host holds
		wr(`SDX_OFS_ARB, 8'h01);
		cyc(2);
		grants(1'b0, 1'b1);
		want = 1'b0;
		cyc(2);
		grants(1'b1, 1'b0);
		chk("abort", 8'(host_cycle_abort_q), 8'h01);
		rd(`SDX_OFS_ARB, 8'h03);
		want = 1'b1;
		cyc(3);
		grants(1'b1, 1'b0);
		wr(`SDX_OFS_ARB, 8'hfa);
		cyc(3);
		grants(1'b0, 1'b1);
		rd(`SDX_OFS_ARB, 8'h00);
		// override takes the bus from the host at once
		wr(`SDX_OFS_ARB, 8'h04);
		cyc(1);
		grants(1'b1, 1'b0);
		chk("abort", 8'(host_cycle_abort_q), 8'h01);
		chk("host_owns", 8'(host_owns), 8'h00);
		cyc(1);
		chk("abort", 8'(host_cycle_abort_q), 8'h00);
		rd(`SDX_OFS_ARB, 8'h06);
		wr(`SDX_OFS_ARB, 8'h00);
		cyc(3);
		grants(1'b0, 1'b1);
		$display("arbitration done");
		// lock freezes the disable register until pci reset
		wr(`SDX_OFS_DDR, 8'h8a);
		wr(`SDX_OFS_DDR, 8'h00);
		rd(`SDX_OFS_DDR, 8'h8a);
		wr(`SDX_OFS_ARB, 8'h05);
		pci_reset = 1'b1;
		cyc(2);
		pci_reset = 1'b0;
		rd(`SDX_OFS_DDR, 8'h00);
		rd(`SDX_OFS_ARB, 8'h00);
		wr(`SDX_OFS_DDR, 8'h88);
		rd(`SDX_OFS_DDR, 8'h88);
		$display("lock and reset done");
		wrap_up;
	end
endmodule
